// *** hdl/reset_strap_sampler.sv ***
/*
 * Reset strap sampler: catches strap levels on the shared pins as the
 * external reset pin is released, holds them, then turns the pins over
 * to their indicator and serial functions.
 * Assumes all pin inputs are synchronous to sys_clk and that the
 * package/configuration logic supplies the strap enables.
 */
module reset_strap_sampler
    import strap_pkg::*;
#(
    parameter int PORTS = 7
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic             reset_pin_n,
    input  wire logic             drive_strap_en,
    input  wire logic             fixed_strap_en,
    input  wire logic             led_support_en,
    input  wire logic [1:0]       led_on_req,
    input  wire logic             suspend_active,
    input  wire logic             serial_drive_low,
    input  wire logic [PORTS:1]   port_overcurrent_in,
    input  wire logic [1:0]       enh_port_indicator_in,
    output logic      [1:0]       enh_port_indicator_out,
    output logic      [1:0]       enh_port_indicator_oe_n,
    input  wire logic             serial_data_in,
    output logic                  serial_data_out,
    output logic                  serial_data_oe_n,
    input  wire logic             suspend_indicator_in,
    output logic                  suspend_indicator_out,
    output logic                  suspend_indicator_oe_n,
    output logic      [1:0]       phy_current_level,
    output logic      [7:0]       upstream_phy_drive_level,
    output logic      [7:0]       downstream_phy_drive_level,
    output logic      [2:0]       fixed_port_mask,
    output logic      [PORTS:1]   overcurrent_flag,
    output logic                  strap_done
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] decode_fixed(input logic [1:0] code);
        case (code)
            FIXED_NONE:   decode_fixed = MASK_NONE;
            FIXED_PORT1:  decode_fixed = MASK_PORT1;
            FIXED_PORT12: decode_fixed = MASK_PORT12;
            default:      decode_fixed = MASK_PORT123;
        endcase
    endfunction

    // Pin level for a lit/unlit indicator under the sampled polarity
    function automatic logic led_level(input logic on, input logic [1:0] lvl);
        led_level = (lvl == LEVEL_HIGH_LED) ? on : ~on;
    endfunction

    function automatic logic [7:0] drive_reg(input logic [1:0] lvl);
        drive_reg = DRIVE_RESET;
        drive_reg[DRIVE_FIELD_LSB +: 2] = lvl;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t          mode;
        logic           pin_q;
        logic [1:0]     level;
        logic [2:0]     fixed;
        logic [PORTS:1] oc;
        logic [1:0]     led_out;
        logic [1:0]     led_oe_n;
        logic           sda_out;
        logic           sda_oe_n;
        logic           susp_out;
        logic           susp_oe_n;
    } state_t;

    localparam state_t STATE_RESET = '{
        mode:      ST_HELD,
        pin_q:     1'b0,
        level:     LEVEL_NORMAL,
        fixed:     MASK_NONE,
        oc:        '0,
        led_out:   2'h0,
        led_oe_n:  2'h3,
        sda_out:   1'b0,
        sda_oe_n:  1'b1,
        susp_out:  1'b0,
        susp_oe_n: 1'b1
    };

    state_t s_q;
    state_t s_d;

    logic   release_edge;
    assign release_edge = reset_pin_n & ~s_q.pin_q;

    always_comb begin
        s_d = s_q;
        if (clk_en) begin
            s_d.pin_q = reset_pin_n;
            s_d.oc = ~port_overcurrent_in;
            case (s_q.mode)
                ST_HELD: begin
                    // Pins stay released so the strap resistors set them
                    s_d.led_oe_n  = 2'h3;
                    s_d.sda_oe_n  = 1'b1;
                    s_d.susp_oe_n = 1'b1;
                    if (release_edge) begin
                        s_d.mode  = ST_RUN;
                        s_d.level = drive_strap_en ?
                                    enh_port_indicator_in : LEVEL_NORMAL;
                        s_d.fixed = fixed_strap_en ?
                                    decode_fixed({serial_data_in,
                                                  suspend_indicator_in})
                                    : MASK_NONE;
                    end
                end
                ST_RUN: begin
                    if (!reset_pin_n) begin
                        // Let go of the pins at once, else the next rise samples our own drive
                        s_d.mode      = ST_HELD;
                        s_d.led_oe_n  = 2'h3;
                        s_d.sda_oe_n  = 1'b1;
                        s_d.susp_oe_n = 1'b1;
                    end else begin
                        // Pins go to their normal use, polarity from the strap
                        for (int i = 0; i < 2; i++) begin
                            s_d.led_out[i] = led_level(led_on_req[i] & led_support_en,
                                                       s_q.level);
                        end
                        s_d.led_oe_n  = 2'h0;
                        s_d.sda_out   = 1'b0;
                        s_d.sda_oe_n  = ~serial_drive_low;
                        s_d.susp_out  = suspend_active;
                        s_d.susp_oe_n = 1'b0;
                    end
                end
                default: s_d = STATE_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign enh_port_indicator_out     = s_q.led_out;
    assign enh_port_indicator_oe_n    = s_q.led_oe_n;
    assign serial_data_out            = s_q.sda_out;
    assign serial_data_oe_n           = s_q.sda_oe_n;
    assign suspend_indicator_out      = s_q.susp_out;
    assign suspend_indicator_oe_n     = s_q.susp_oe_n;
    assign phy_current_level          = s_q.level;
    // One strap drives every transceiver, so both registers mirror it
    assign upstream_phy_drive_level   = drive_reg(s_q.level);
    assign downstream_phy_drive_level = drive_reg(s_q.level);
    assign fixed_port_mask            = s_q.fixed;
    assign overcurrent_flag           = s_q.oc;
    assign strap_done                 = (s_q.mode == ST_RUN);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence held_release_s;
        s_q.mode == ST_HELD && clk_en && release_edge;
    endsequence

    sequence run_steady_s;
        s_q.mode == ST_RUN && clk_en && reset_pin_n;
    endsequence

    sample_drive_a: assert property (held_release_s and drive_strap_en
        |=> phy_current_level == $past(enh_port_indicator_in))
        else $error("drive strap not captured at release");

    strap_gate_a: assert property (held_release_s and !drive_strap_en
        |=> phy_current_level == LEVEL_NORMAL)
        else $error("disabled drive strap was sampled");

    fixed_decode_a: assert property (held_release_s and fixed_strap_en
        |=> fixed_port_mask ==
            decode_fixed({$past(serial_data_in), $past(suspend_indicator_in)}))
        else $error("fixed-device strap decoded wrongly");

    strap_hold_a: assert property (run_steady_s
        |=> $stable(phy_current_level) && $stable(fixed_port_mask))
        else $error("strap value changed while running");

    led_high_a: assert property (run_steady_s and led_support_en
        and phy_current_level == LEVEL_HIGH_LED and led_on_req[0]
        |=> enh_port_indicator_out[0] == 1'b1)
        else $error("indicator not active high for strap 00");

    led_low_a: assert property (run_steady_s and led_support_en
        and phy_current_level != LEVEL_HIGH_LED and led_on_req[1]
        |=> enh_port_indicator_out[1] == 1'b0)
        else $error("indicator not active low");

    overcurrent_a: assert property (clk_en && !port_overcurrent_in[1]
        |=> overcurrent_flag[1])
        else $error("over-current low level not flagged");

    pin_release_a: assert property (held_release_s
        |=> strap_done ##1 (!$past(reset_pin_n) || !$past(clk_en)
                            || enh_port_indicator_oe_n == 2'h0))
        else $error("shared pins not handed over after sampling");

    pins_free_a: assert property (clk_en && s_q.mode == ST_HELD && !reset_pin_n
        |=> enh_port_indicator_oe_n == 2'h3 && serial_data_oe_n)
        else $error("shared pins driven during strap window");

    reentry_release_a: assert property (clk_en && s_q.mode == ST_RUN && !reset_pin_n
        |=> enh_port_indicator_oe_n == 2'h3 && serial_data_oe_n && suspend_indicator_oe_n)
        else $error("shared pins still driven after reset pin fell");

endmodule

// *** hdl/strap_pkg.sv ***
/*
 * Constants for the reset strap sampler: strap codes, register offsets,
 * field positions and reset values.
 * Assumes it is compiled before any design file that imports it.
 */
package strap_pkg;

    // ------------------------------------------------------------
    // Drive level registers (offsets as seen by the config port)
    // ------------------------------------------------------------
    localparam logic [7:0] UP_DRIVE_OFFSET   = 8'hF6;
    localparam logic [7:0] DOWN_DRIVE_OFFSET = 8'hF8;
    localparam int         DRIVE_FIELD_LSB   = 0;
    localparam logic [7:0] DRIVE_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Strap codes
    // ------------------------------------------------------------
    localparam logic [1:0] LEVEL_NORMAL      = 2'h0;
    localparam logic [1:0] LEVEL_HIGH_LED    = 2'h0;
    localparam logic [1:0] FIXED_NONE        = 2'h0;
    localparam logic [1:0] FIXED_PORT1       = 2'h1;
    localparam logic [1:0] FIXED_PORT12      = 2'h2;
    localparam logic [2:0] MASK_NONE         = 3'h0;
    localparam logic [2:0] MASK_PORT1        = 3'h1;
    localparam logic [2:0] MASK_PORT12       = 3'h3;
    localparam logic [2:0] MASK_PORT123      = 3'h7;

    typedef enum logic [1:0] {
        ST_HELD = 2'h1,
        ST_RUN  = 2'h2
    } mode_t;

endpackage

// *** dv/strap_board.sv ***
/*
 * Board model: strap resistors on the shared indicator, serial and suspend
 * pins.
 * Assumes the sampler's oe_n outputs are low while it drives a pin.
 */
module strap_board (
    input  wire logic [1:0] drive_code,
    input  wire logic [1:0] fixed_code,
    input  wire logic [1:0] ind_out,
    input  wire logic [1:0] ind_oe_n,
    input  wire logic       serial_oe_n,
    input  wire logic       susp_out,
    input  wire logic       susp_oe_n,
    output logic      [1:0] ind_pin,
    output logic            serial_pin,
    output logic            susp_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Released pins settle to the strap resistor level
    // ------------------------------------------------------------
    assign ind_pin[0] = ind_oe_n[0] ? drive_code[0] : ind_out[0];
    assign ind_pin[1] = ind_oe_n[1] ? drive_code[1] : ind_out[1];
    // Open drain: only ever pulled low by the sampler
    assign serial_pin = serial_oe_n ? fixed_code[1] : 1'b0;
    assign susp_pin   = susp_oe_n ? fixed_code[0] : susp_out;
endmodule

// *** dv/reset_strap_sampler_test.sv ***
/*
 * Self-checking bench for the reset strap sampler.
 * Assumes the board model in strap_board and a free-running 125 MHz clock.
 */
module reset_strap_sampler_test
    import strap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst = 1, reset_pin_n = 0, den = 0, fen = 0, led_en = 0, susp_act = 0;
    logic [1:0] led_req = 0, drive_code = 0, fixed_code = 0, ind_pin, ind_out, ind_oe_n, lvl;
    logic [7:1] oc_in = 7'h7F, oc_flag;
    logic serial_pin, serial_oe_n, susp_pin, susp_out, susp_oe_n, done;
    logic ce = 1, sdl = 0, serial_out;
    logic [7:0] up_lvl, dn_lvl;
    logic [2:0] mask;
    int err_total = 0, checks = 0;
    always #4 sys_clk = ~sys_clk;
    reset_strap_sampler uut (.sys_clk(sys_clk), .rst(rst), .clk_en(ce),
        .reset_pin_n(reset_pin_n), .drive_strap_en(den), .fixed_strap_en(fen),
        .led_support_en(led_en), .led_on_req(led_req), .suspend_active(susp_act),
        .serial_drive_low(sdl), .port_overcurrent_in(oc_in), .enh_port_indicator_in(ind_pin),
        .enh_port_indicator_out(ind_out), .enh_port_indicator_oe_n(ind_oe_n),
        .serial_data_in(serial_pin), .serial_data_out(serial_out), .serial_data_oe_n(serial_oe_n),
        .suspend_indicator_in(susp_pin), .suspend_indicator_out(susp_out),
        .suspend_indicator_oe_n(susp_oe_n), .phy_current_level(lvl),
        .upstream_phy_drive_level(up_lvl), .downstream_phy_drive_level(dn_lvl),
        .fixed_port_mask(mask), .overcurrent_flag(oc_flag), .strap_done(done));
    strap_board board (.drive_code(drive_code), .fixed_code(fixed_code), .ind_out(ind_out),
        .ind_oe_n(ind_oe_n), .serial_oe_n(serial_oe_n), .susp_out(susp_out),
        .susp_oe_n(susp_oe_n), .ind_pin(ind_pin), .serial_pin(serial_pin), .susp_pin(susp_pin));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Pulse the reset pin low, present straps, return once outputs settle
    task automatic sample(input logic [1:0] dc, input logic [1:0] fc, input logic en);
        @(posedge sys_clk);
        #1 reset_pin_n = 0;
        drive_code = dc;
        fixed_code = fc;
        den = en;
        fen = en;
        repeat (2) @(posedge sys_clk);
        #1 reset_pin_n = 1;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_decode();
        logic [2:0] exp_mask[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        for (int i = 0; i < 4; i++) begin
            sample(2'(i), 2'(3 - i), 1'b1);
            chk("level", {6'h00, lvl}, 8'(i));
            chk("up_reg", up_lvl, 8'(i));
            chk("down_reg", dn_lvl, 8'(i));
            chk("mask", {5'h00, mask}, {5'h00, exp_mask[3 - i]});
            chk("done", {7'h00, done}, 8'h01);
        end
    endtask
    task automatic test_disabled();
        sample(2'h3, 2'h3, 1'b0);
        chk("level_off", {6'h00, lvl}, 8'h00);
        chk("mask_off", {5'h00, mask}, 8'h00);
    endtask
    task automatic test_hold();
        sample(2'h2, 2'h1, 1'b1);
        drive_code = 2'h1;
        fixed_code = 2'h3;
        repeat (6) @(posedge sys_clk);
        #1 chk("level_held", {6'h00, lvl}, 8'h02);
        chk("mask_held", {5'h00, mask}, 8'h01);
    endtask
    task automatic test_indicators();
        logic [1:0] lv[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
        for (int i = 0; i < 4; i++) begin
            sample(lv[i], 2'h0, 1'b1);
            led_en = 1;
            led_req = 2'b01;
            susp_act = 1;
            @(posedge sys_clk);
            #1 chk("ind_oe_n", {6'h00, ind_oe_n}, 8'h00);
            chk("susp_oe_n", {7'h00, susp_oe_n}, 8'h00);
            chk("susp_out", {7'h00, susp_out}, 8'h01);
            chk("ind_lit", {6'h00, ind_out}, (i == 0) ? 8'h01 : 8'h02);
            led_en = 0;
            susp_act = 0;
            @(posedge sys_clk);
            #1 chk("ind_dark", {6'h00, ind_out}, (i == 0) ? 8'h00 : 8'h03);
        end
    endtask
    task automatic test_overcurrent();
        logic [6:0] pat[3] = '{7'h7E, 7'h2A, 7'h7F};
        for (int i = 0; i < 3; i++) begin
            oc_in = pat[i];
            @(posedge sys_clk);
            #1 chk("oc_flag", {1'b0, oc_flag}, {1'b0, ~pat[i]});
        end
    endtask
    // Serial open-drain use, then strap window re-entry from run
    task automatic test_pins();
        sample(2'h1, 2'h2, 1'b1);
        sdl = 1;
        @(posedge sys_clk);
        #1 chk("sda_oe_n", {7'h00, serial_oe_n}, 8'h00);
        chk("sda_out", {7'h00, serial_out}, 8'h00);
        chk("sda_pin", {7'h00, serial_pin}, 8'h00);
        sdl = 0;
        @(posedge sys_clk);
        #1 chk("sda_free", {7'h00, serial_oe_n}, 8'h01);
        reset_pin_n = 0;
        @(posedge sys_clk);
        #1 chk("win_ind_oe_n", {6'h00, ind_oe_n}, 8'h03);
        chk("win_sda_oe_n", {7'h00, serial_oe_n}, 8'h01);
        chk("win_susp_oe_n", {7'h00, susp_oe_n}, 8'h01);
        reset_pin_n = 1;
        repeat (2) @(posedge sys_clk);
        #1 chk("win_level", {6'h00, lvl}, 8'h01);
        chk("win_mask", {5'h00, mask}, 8'h03);
    endtask
    task automatic test_freeze();
        sample(2'h2, 2'h3, 1'b1);
        ce = 0;
        reset_pin_n = 0;
        drive_code = 2'h1;
        oc_in = 7'h00;
        repeat (3) @(posedge sys_clk);
        #1 reset_pin_n = 1;
        repeat (3) @(posedge sys_clk);
        #1 chk("frz_done", {7'h00, done}, 8'h01);
        chk("frz_oe_n", {6'h00, ind_oe_n}, 8'h00);
        chk("frz_oc", {1'b0, oc_flag}, 8'h00);
        ce = 1;
        oc_in = 7'h7F;
        repeat (2) @(posedge sys_clk);
        #1 chk("frz_level", {6'h00, lvl}, 8'h02);
        chk("frz_mask", {5'h00, mask}, 8'h07);
    endtask
    // Mid-run reset with the reset pin already high resamples at once
    task automatic test_rst();
        sample(2'h3, 2'h1, 1'b1);
        rst = 1;
        #1 chk("rst_done", {7'h00, done}, 8'h00);
        chk("rst_level", {6'h00, lvl}, 8'h00);
        chk("rst_oe_n", {6'h00, ind_oe_n}, 8'h03);
        chk("rst_sda_oe_n", {7'h00, serial_oe_n}, 8'h01);
        @(posedge sys_clk);
        #1 rst = 0;
        @(posedge sys_clk);
        #1 chk("rst_resample", {6'h00, lvl}, 8'h03);
        chk("rst_mask", {5'h00, mask}, 8'h01);
    endtask
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst = 0;
        test_decode();
        test_disabled();
        test_hold();
        test_indicators();
        test_pins();
        test_overcurrent();
        test_freeze();
        test_rst();
        summarize();
    end
endmodule
